// *** rtl/drpd_ctrl.sv ***
`timescale 1ns/1ps
module drpd_ctrl
	import drpd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	drpd_if.ctrl link,
	input wire logic pd_req,
	input wire logic sref_req,
	output logic busy_q,
	output logic [3:0] debt_q
);
	typedef enum logic [2:0] {
		CS_IDLE, CS_RFC, CS_SREF, CS_XSR, CS_PD, CS_XP
	} drpd_cstate_e;
	drpd_cstate_e st_q;
	logic [CNT_W-1:0] tmr_q;
	logic [CNT_W-1:0] refi_q;
	logic cke_q;
	drpd_cmd_s cmd_q;
	logic need_ref_q;
	assign link.cke = cke_q;
	assign link.cmd = cmd_q;
	assign link.ba = '0;
	assign link.addr = '0;
	assign link.odt = 1'b0; // RL8 RL13 RL22
	wire tick = refi_q == '0;
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			refi_q <= CNT_W'(REFI_CYC - 1);
		else if (ce)
			refi_q <= tick ? CNT_W'(REFI_CYC - 1) : refi_q - 1'b1;
	end
	// forced at the posting limit, owed after self refresh exit, else when nothing else waits
	wire ref_due = debt_q >= 4'(POST_MAX) || (debt_q != '0 && !sref_req && !pd_req) ||
		(need_ref_q && sref_req);
	wire issue_ref = st_q == CS_IDLE && tmr_q == '0 && ref_due;
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			debt_q <= '0;
		else if (ce)
			debt_q <= debt_q + {3'h0, tick && debt_q != 4'hF} -
				{3'h0, issue_ref && debt_q != '0}; // RL23
	end
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st_q <= CS_IDLE;
			tmr_q <= '0;
			cke_q <= 1'b0;
			cmd_q <= CMD_NOP;
			need_ref_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (ce)
		begin
			cmd_q <= CMD_NOP;
			cke_q <= 1'b1;
			if (tmr_q != '0)
				tmr_q <= tmr_q - 1'b1;
			case (st_q)
				CS_IDLE:
				begin
					busy_q <= 1'b0;
					// RL2: no rows opened by this end, banks stay idle
					if (tmr_q != '0)
						;
					else if (issue_ref)
					begin
						cmd_q <= CMD_REF; // RL6
						st_q <= CS_RFC;
						tmr_q <= CNT_W'(RFC_CYC); // RL5
						need_ref_q <= 1'b0;
						busy_q <= 1'b1;
					end
					else if (sref_req && !need_ref_q)
					begin
						cmd_q <= CMD_REF;
						cke_q <= 1'b0; // RL7
						st_q <= CS_SREF;
						tmr_q <= CNT_W'(CKE_CYC); // RL11
						busy_q <= 1'b1;
					end
					else if (pd_req)
					begin
						cke_q <= 1'b0; // RL15 RL20
						st_q <= CS_PD;
						tmr_q <= CNT_W'(CKE_CYC + FREQ_WAIT_CK); // RL18
						busy_q <= 1'b1;
					end
				end
				CS_RFC:
					if (tmr_q == CNT_W'(1))
						st_q <= CS_IDLE;
				CS_SREF:
				begin
					cke_q <= 1'b0; // RL9 RL12
					if (tmr_q == '0 && !sref_req)
					begin
						cke_q <= 1'b1;
						st_q <= CS_XSR;
						tmr_q <= CNT_W'(T_XSRD_CK); // RL13 RL14
						need_ref_q <= 1'b1;
					end
				end
				CS_PD:
				begin
					cke_q <= 1'b0;
					if (tmr_q == '0 && (!pd_req || debt_q >= 4'(POST_MAX - 1)))
					begin
						cke_q <= 1'b1; // RL19
						st_q <= CS_XP;
						tmr_q <= CNT_W'(T_XP_CK + CKE_CYC);
					end
				end
				CS_XSR, CS_XP:
					if (tmr_q == CNT_W'(1))
						st_q <= CS_IDLE;
				default: st_q <= CS_IDLE;
			endcase
		end
	end
	// RL21: cke never dropped mid-operation, so no async recovery path
endmodule

// *** rtl/drpd_dev.sv ***
`timescale 1ns/1ps
module drpd_dev
	import drpd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	drpd_if.dev link,
	output logic dll_on_q,
	output logic clk_gate_q,
	output logic buf_on_q,
	output logic fast_exit_apd,
	output logic [BA_W-1:0] ref_bank_q,
	output logic [ROW_W-1:0] ref_row_q,
	output logic ref_pulse_q,
	output logic [NBANK-1:0] bank_open_q,
	output drpd_dstate_e state_q
);
	logic cke_q;
	logic cke_p_q;
	drpd_cmd_s cmd_q;
	logic [BA_W-1:0] ba_q;
	logic [CNT_W-1:0] tmr_q;
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cke_q <= 1'b0;
			cke_p_q <= 1'b0;
			cmd_q <= CMD_DES;
			ba_q <= '0;
		end
		else if (ce)
		begin
			cke_q <= link.cke;
			// previous cke: power-down needs a falling cke, not the low level left by reset
			cke_p_q <= cke_q;
			cmd_q <= link.cmd;
			ba_q <= link.ba;
		end
	end
	wire is_ref = cke_q && cmd_q == CMD_REF; // RL1
	wire is_sref = !cke_q && cmd_q == CMD_REF; // RL7
	wire is_nop = cmd_q.cs_n || cmd_q == CMD_NOP;
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_q <= DS_IDLE;
			tmr_q <= '0;
			bank_open_q <= '0;
			ref_bank_q <= '0;
			ref_row_q <= '0;
			ref_pulse_q <= 1'b0;
			dll_on_q <= 1'b1;
			clk_gate_q <= 1'b0;
			buf_on_q <= 1'b1;
		end
		else if (ce)
		begin
			ref_pulse_q <= 1'b0;
			if (tmr_q != '0)
				tmr_q <= tmr_q - 1'b1;
			case (state_q)
				DS_IDLE:
				begin
					if (is_sref && bank_open_q == '0)
					begin
						state_q <= DS_SREF;
						dll_on_q <= 1'b0; // RL10
						clk_gate_q <= 1'b1; // RL10
						buf_on_q <= 1'b0;
						tmr_q <= CNT_W'(CKE_CYC);
					end
					else if (is_ref)
					begin
						state_q <= DS_REF;
						tmr_q <= CNT_W'(RFC_CYC);
					end
					else if (cke_p_q && !cke_q)
					begin
						// RL15 RL16 RL17
						state_q <= bank_open_q == '0 ? DS_PPD : DS_APD;
						buf_on_q <= 1'b0;
						dll_on_q <= bank_open_q != '0 && fast_exit_apd;
					end
					else if (cmd_q == CMD_ACT)
						bank_open_q[ba_q] <= 1'b1;
					else if (cmd_q == CMD_PRE)
						bank_open_q[ba_q] <= 1'b0;
				end
				DS_REF:
				begin
					if (tmr_q == CNT_W'(1))
					begin
						// RL3: row/bank from internal counter; address bus unused
						{ref_row_q, ref_bank_q} <= {ref_row_q, ref_bank_q} + 1'b1;
						ref_pulse_q <= 1'b1;
						bank_open_q <= '0; // RL4
						state_q <= DS_IDLE;
					end
				end
				DS_SREF:
				begin
					// RL9: only cke is looked at
					if (tmr_q == CNT_W'(1))
					begin
						ref_pulse_q <= 1'b1; // RL11
						{ref_row_q, ref_bank_q} <= {ref_row_q, ref_bank_q} + 1'b1;
					end
					if (cke_q && tmr_q == '0)
					begin
						state_q <= DS_XSR;
						dll_on_q <= 1'b1; // RL10
						clk_gate_q <= 1'b0;
						buf_on_q <= 1'b1;
						tmr_q <= CNT_W'(XSNR_CYC);
					end
				end
				DS_PPD, DS_APD:
				begin
					if (cke_q && is_nop)
					begin
						state_q <= DS_IDLE; // RL19
						buf_on_q <= 1'b1;
						dll_on_q <= 1'b1;
					end
				end
				DS_XSR:
				begin
					if (tmr_q == '0)
						state_q <= DS_IDLE;
				end
				default: state_q <= DS_IDLE;
			endcase
		end
	end
	// active power-down always keeps the dll running
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			fast_exit_apd <= 1'b1; // RL17
	end
endmodule

// *** rtl/drpd_if.sv ***
`timescale 1ns/1ps
interface drpd_if;
	import drpd_pkg::*;
	logic cke;
	drpd_pkg::drpd_cmd_s cmd;
	logic [drpd_pkg::BA_W-1:0] ba;
	logic [drpd_pkg::ROW_W-1:0] addr;
	logic odt;
	modport ctrl (output cke, output cmd, output ba, output addr, output odt);
	modport dev (input cke, input cmd, input ba, input addr, input odt);
endinterface

// *** rtl/drpd_pkg.sv ***
// Operation
// [RL1] auto refresh decode: cs/ras/cas low, cke/we high
// [RL2] controller precharges all banks before refresh
// [RL3] internal counter supplies refresh bank and row
// [RL4] all banks idle after refresh completes
// [RL5] controller waits refresh cycle time after refresh
// [RL6] at most eight refreshes postponed, nine intervals
// [RL7] self refresh decode: cke also low
// [RL8] termination off before self refresh entry
// [RL9] cke held low; other inputs ignored
// [RL10] dll off and clock gated in self refresh
// [RL11] internal refresh within cke minimum period
// [RL12] clock may stop one cycle after entry
// [RL13] after exit hold cke, no command
// [RL14] only nop during exit, refresh before reentry
// [RL15] cke low registered enters power-down
// [RL16] precharge or active power-down by open rows
// [RL17] buffers off; dll per power-down kind
// [RL18] power-down held cke minimum, nine intervals max
// [RL19] exit with cke high and nop, latency
// [RL20] enter power-down only with dll locked
// [RL21] async cke drop needs full reinit
// [RL22] frequency change only in precharge power-down
// [RL23] controller tracks refresh debt, forces refresh
package drpd_pkg;
	localparam int CLK_MHZ = 25;
	localparam int T_CKE_NS = 8;
	localparam int T_RFC_NS = 128;
	localparam int T_XSNR_NS = 138;
	localparam int T_XP_CK = 2;
	localparam int T_XSRD_CK = 200;
	localparam int T_REFI_NS = 7800;
	localparam int FREQ_WAIT_CK = 2;
	// least times round up, at least one cycle
	localparam int CKE_CYC = (T_CKE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
		(T_CKE_NS * CLK_MHZ + 999) / 1000;
	localparam int RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
	localparam int XSNR_CYC = (T_XSNR_NS * CLK_MHZ + 999) / 1000;
	localparam int REFI_CYC = (T_REFI_NS * CLK_MHZ) / 1000;
	localparam int POST_MAX = 8;
	localparam int NBANK = 4;
	localparam int ROW_W = 13;
	localparam int BA_W = 2;
	localparam int CNT_W = 16;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} drpd_cmd_s;
	localparam drpd_cmd_s CMD_NOP = 4'h7;
	localparam drpd_cmd_s CMD_REF = 4'h1;
	localparam drpd_cmd_s CMD_ACT = 4'h3;
	localparam drpd_cmd_s CMD_PRE = 4'h2;
	localparam drpd_cmd_s CMD_DES = 4'hF;
	typedef enum logic [2:0] {
		DS_IDLE, DS_REF, DS_SREF, DS_PPD, DS_APD, DS_XSR
	} drpd_dstate_e;
endpackage

// *** test/drpd_monitor.sv ***
`timescale 1ns/1ps
module drpd_monitor
	import drpd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cke,
	input wire drpd_pkg::drpd_cmd_s cmd,
	input wire logic [drpd_pkg::BA_W-1:0] ba,
	input wire logic [drpd_pkg::ROW_W-1:0] addr,
	input wire logic odt
);
	localparam logic [11:0] GAP_MAX = 12'(9 * REFI_CYC);
	logic cke_q, sref_q, ref_seen_q;
	logic [11:0] gap_q;
	wire nopdes = cmd.cs_n || cmd == CMD_NOP;
	wire ent = cke_q && !cke && cmd == CMD_REF;
	wire ext = sref_q && cke;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	always_ff @(posedge clk_sys) cke_q <= srst ? 1'b0 : cke;
	always_ff @(posedge clk_sys) sref_q <= srst ? 1'b0 : ent || (sref_q && !cke);
	// a refresh is owed after every self refresh exit
	always_ff @(posedge clk_sys) ref_seen_q <= srst || (cmd == CMD_REF && cke) || (ref_seen_q && !ext);
	always_ff @(posedge clk_sys) gap_q <= (srst || sref_q || cmd == CMD_REF) ? 12'h000 : gap_q + 12'h001;
	a_odt_held_low: assert property (!odt)
		else $error("odt driven high");
	a_ref_spacing: assert property (cmd == CMD_REF && cke |=> (cmd != CMD_REF && cmd != CMD_ACT)[*3])
		else $error("refresh cycle time violated");
	a_exit_with_nop: assert property ($rose(cke) |-> nopdes)
		else $error("cke rose without nop");
	a_xsnr_quiet_period: assert property (ext |-> (cke && nopdes)[*4])
		else $error("command during self refresh exit");
	a_reentry_after_ref: assert property (ent |-> ref_seen_q)
		else $error("self refresh reentered without refresh");
	a_no_row_open: assert property (!(cke && cmd == CMD_ACT))
		else $error("activate issued");
	a_pd_entry_cmd: assert property ($fell(cke) |-> nopdes || cmd == CMD_REF)
		else $error("cke fell with illegal command");
	a_refresh_gap: assert property (gap_q <= GAP_MAX)
		else $error("refresh interval exceeded");
	c_sref_exit: cover property (ext);
	c_pd_entry: cover property ($fell(cke) && nopdes);
	c_auto_ref: cover property (cmd == CMD_REF && cke);
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import drpd_pkg::*;
	typedef struct packed {logic pd; logic sr; drpd_dstate_e st; logic dll; logic lvl;} drpd_row_s;
	logic clk_sys, srst, ce, pd_req, sref_req, dll_on, gate, buf_on, fast, rp, busy, have_prev;
	logic [BA_W-1:0] rb;
	logic [ROW_W-1:0] rr;
	logic [NBANK-1:0] bo;
	logic [3:0] debt;
	logic [15:0] prev_cnt;
	drpd_dstate_e st;
	int failures, total_checks, cyc, n;
	drpd_row_s rows [6];
	drpd_if lnk();
	drpd_ctrl i_drpd_ctrl(.clk_sys(clk_sys), .srst(srst), .ce(ce), .link(lnk.ctrl),
		.pd_req(pd_req), .sref_req(sref_req), .busy_q(busy), .debt_q(debt));
	drpd_dev i_drpd_dev(.clk_sys(clk_sys), .srst(srst), .ce(ce), .link(lnk.dev),
		.dll_on_q(dll_on), .clk_gate_q(gate), .buf_on_q(buf_on), .fast_exit_apd(fast),
		.ref_bank_q(rb), .ref_row_q(rr), .ref_pulse_q(rp), .bank_open_q(bo), .state_q(st));
	drpd_monitor i_drpd_monitor(.clk_sys(clk_sys), .srst(srst), .cke(lnk.cke), .cmd(lnk.cmd),
		.ba(lnk.ba), .addr(lnk.addr), .odt(lnk.odt));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wait_st(input drpd_dstate_e e);
		n = 0;
		while (st !== e && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			complete_run();
		end
	end
	// refresh counter steps by one per refresh, banks idle after
	always @(negedge clk_sys)
	begin
		if (srst)
			have_prev = 1'b0;
		else if (rp === 1'b1)
		begin
			if (have_prev)
				chk({1'b0, rr, rb}, prev_cnt + 16'h0001);
			chk(16'(bo), 16'h0000);
			prev_cnt = {1'b0, rr, rb};
			have_prev = 1'b1;
		end
	end
	initial
	begin
		srst = 1'b1;
		ce = 1'b1;
		pd_req = 1'b0;
		sref_req = 1'b0;
		have_prev = 1'b0;
		rows = '{'{1'b1, 1'b0, DS_PPD, 1'b0, 1'b0}, '{1'b0, 1'b0, DS_IDLE, 1'b1, 1'b1},
			'{1'b0, 1'b1, DS_SREF, 1'b0, 1'b0}, '{1'b0, 1'b0, DS_IDLE, 1'b1, 1'b1},
			'{1'b0, 1'b1, DS_SREF, 1'b0, 1'b0}, '{1'b0, 1'b0, DS_IDLE, 1'b1, 1'b1}};
		repeat (20) @(negedge clk_sys);
		chk(16'(lnk.cke), 16'h0000);
		chk(16'(lnk.cmd), 16'(CMD_NOP));
		srst = 1'b0;
		@(negedge clk_sys);
		chk(16'(st), 16'(DS_IDLE));
		chk(16'(dll_on), 16'h0001);
		chk(16'(fast), 16'h0001);
		chk(16'(busy), 16'h0000);
		chk(16'(debt), 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			pd_req = rows[i].pd;
			sref_req = rows[i].sr;
			wait_st(rows[i].st);
			chk(16'(st), 16'(rows[i].st));
			chk(16'(dll_on), 16'(rows[i].dll));
			chk(16'(rows[i].st == DS_SREF ? !gate : buf_on), 16'(rows[i].lvl));
			$display("test %0d done", i);
		end
		repeat (800) @(negedge clk_sys);
		chk(16'(debt <= 4'h1), 16'h0001);
		$display("test refresh done");
		sref_req = 1'b1;
		wait_st(DS_SREF);
		srst = 1'b1;
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		sref_req = 1'b0;
		@(negedge clk_sys);
		chk(16'(st), 16'(DS_IDLE));
		chk(16'(dll_on), 16'h0001);
		chk(16'(gate), 16'h0000);
		chk(16'(busy), 16'h0000);
		$display("test reset done");
		complete_run();
	end
endmodule
